/* rtl/diode_cfg_bank.sv */
// Purpose: diode channel configuration and critical limit register bank
// Assumes: register port driven by the serial bus engine on CLK_SYS_I
// Notes:   conversion engine, lock register and status read are outside
`timescale 1ns/1ps
module diode_cfg_bank
	import diode_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                CLK_SYS_I,
	input  wire logic                RSTN_I,
	// register port
	input  wire logic [7:0]          REG_ADDR_I,
	input  wire logic                REG_WR_I,
	input  wire logic [7:0]          REG_WDATA_I,
	input  wire logic                REG_RD_I,
	output logic      [7:0]          REG_RDATA_O,
	// hardware configuration pins
	input  wire logic                SHUTDOWN_CHANNEL_SELECT_PIN_D1_I,
	input  wire logic                SHUTDOWN_CHANNEL_SELECT_PIN_D2_I,
	input  wire logic                SHDN_REC_I,
	input  wire logic                GAIN_COMP_DIS_D1_I,
	input  wire logic                GAIN_COMP_DIS_D2_I,
	input  wire logic [1:0]          REC_STRAP_I,
	// from lock register and conversion engine
	input  wire logic                SW_LOCK_I,
	input  wire logic                D3_EN_I,
	input  wire logic                DET_VALID_I,
	input  wire logic [2:0]          DET_RANGE_D1_I,
	input  wire logic [2:0]          DET_RANGE_D2_I,
	input  wire logic [7:0]          TEMP_D1_I,
	input  wire logic [7:0]          TEMP_D2_I,
	input  wire logic [7:0]          TEMP_D3_I,
	input  wire logic [7:0]          TEMP_INT_I,
	input  wire logic                CRIT_STAT_CLR_I,
	// to compensation circuitry
	output logic      [2:0]          COMPENSATION_RANGE_D1_O,
	output logic      [2:0]          COMPENSATION_RANGE_D2_O,
	output logic      [2:0]          COMPENSATION_RANGE_D3_O,
	output logic      [1:0]          COMP_ACTIVE_O,
	output logic      [1:0]          GAIN_DETECT_ENABLE_O,
	output logic      [2:0]          SERIES_RES_CORRECT_O,
	// shutdown and status
	output logic                     SYSTEM_SHUTDOWN_N_O,
	output logic      [NUM_CRIT-1:0] CRIT_STATUS_O,
	output logic      [NUM_CRIT-1:0] CRIT_LINKED_O,
	output logic                     CRIT_SUMMARY_O
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic [1:0]        strap_meta_q;
	logic [1:0]        strap_q;

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			meta_q       <= '0;
			sync_q       <= '0;
			strap_meta_q <= '0;
			strap_q      <= '0;
		end
		else
		begin
			meta_q       <= {SHDN_REC_I, GAIN_COMP_DIS_D2_I, GAIN_COMP_DIS_D1_I, SHUTDOWN_CHANNEL_SELECT_PIN_D2_I, SHUTDOWN_CHANNEL_SELECT_PIN_D1_I};
			sync_q       <= meta_q;
			strap_meta_q <= REC_STRAP_I;
			strap_q      <= strap_meta_q;
		end
	end

	wire [1:0] sel_w     = sync_q[1:0];
	wire [1:0] gdis_w    = sync_q[3:2];
	wire       shdn_rec_w = sync_q[4];

	// ----------------------------------------
	// gain compensation registers
	// ----------------------------------------
	wire  [1:0]      auto_q;
	wire  [1:0][2:0] range_q;
	wire  [1:0]      gain_ro_w = sel_w | {2{SW_LOCK_I}};
	wire  [1:0][2:0] det_w     = {DET_RANGE_D2_I, DET_RANGE_D1_I};
	wire  [1:0]      gain_hit_w = {REG_ADDR_I == ADDR_GAIN_D2, REG_ADDR_I == ADDR_GAIN_D1};

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gain_ch
			// per-channel flops, joined on nets so each has one writer
			logic       auto_r;
			logic [2:0] range_r;
			wire        gwr_w = REG_WR_I && gain_hit_w[g] && !gain_ro_w[g];
			always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
			begin
				if (!RSTN_I)
				begin
					auto_r  <= GAIN_AUTO_RESET;
					range_r <= GAIN_RANGE_RESET;
				end
				else if (gdis_w[g])
				begin
					auto_r  <= 1'b0;
					range_r <= RANGE_DISABLED;
				end
				else if (gwr_w)
				begin
					auto_r  <= REG_WDATA_I[GAIN_AUTO_BIT];
					range_r <= REG_WDATA_I[2:0];
				end
				else if (auto_r && DET_VALID_I)
					range_r <= det_w[g];
			end
			assign auto_q[g]  = auto_r;
			assign range_q[g] = range_r;
		end
	endgenerate

	// ----------------------------------------
	// resistance correction register
	// ----------------------------------------
	logic [2:0] rec_q;
	logic [2:0] init_q;
	wire        rec_wr_w = REG_WR_I && (REG_ADDR_I == ADDR_REC) && !SW_LOCK_I;

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			rec_q  <= {REC_D3_RESET, 2'h0};
			init_q <= 3'h1;
		end
		else
		begin
			// strap is only valid after two sync edges: load on the third
			init_q <= {init_q[1:0], 1'b0};
			if (rec_wr_w)
				rec_q <= REG_WDATA_I[2:0];
			else if (init_q[2])
				rec_q[1:0] <= strap_q;
			if (sel_w[0])
				rec_q[0] <= shdn_rec_w;
			if (sel_w[1])
				rec_q[1] <= shdn_rec_w;
		end
	end

	// ----------------------------------------
	// critical limit channels
	// ----------------------------------------
	crit_if cif [NUM_CRIT] ();
	wire [NUM_CRIT-1:0]      csel_w = crit_sel(REG_ADDR_I);
	wire [NUM_CRIT-1:0][7:0] temp_w = {TEMP_INT_I, TEMP_D3_I, TEMP_D2_I, TEMP_D1_I};
	wire [NUM_CRIT-1:0]      over_w;
	wire [NUM_CRIT-1:0]      stat_w;
	wire [NUM_CRIT-1:0]      link_w;
	wire [NUM_CRIT-1:0][7:0] limit_w;

	genvar c;
	generate
		for (c = 0; c < NUM_CRIT; c++)
		begin : crit_ch
			assign cif[c].wr    = REG_WR_I && csel_w[c];
			assign cif[c].wdata = REG_WDATA_I;
			assign cif[c].temp  = temp_w[c];
			assign cif[c].clr   = CRIT_STAT_CLR_I;
			assign over_w[c]    = cif[c].over;
			assign stat_w[c]    = cif[c].stat;
			assign link_w[c]    = cif[c].linked;
			assign limit_w[c]   = cif[c].limit;
			crit_chan u_chan (
				.clk_i  (CLK_SYS_I),
				.rstn_i (RSTN_I),
				.bus    (cif[c])
			);
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [7:0] rdata_d;
	always_comb
	begin
		if (REG_ADDR_I == ADDR_GAIN_D1)
			rdata_d = {3'h0, auto_q[0], 1'b0, range_q[0]};
		else if (REG_ADDR_I == ADDR_GAIN_D2)
			rdata_d = {3'h0, auto_q[1], 1'b0, range_q[1]};
		else if (REG_ADDR_I == ADDR_REC)
			rdata_d = {5'h0, rec_q};
		else if (csel_w[0])
			rdata_d = limit_w[0];
		else if (csel_w[1])
			rdata_d = limit_w[1];
		else if (csel_w[2])
			rdata_d = limit_w[2];
		else if (csel_w[3])
			rdata_d = limit_w[3];
		else
			rdata_d = READ_UNMAPPED;
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			REG_RDATA_O             <= '0;
			COMPENSATION_RANGE_D3_O <= RANGE_DISABLED;
			COMP_ACTIVE_O           <= '0;
			SYSTEM_SHUTDOWN_N_O     <= 1'b1;
			CRIT_SUMMARY_O          <= 1'b0;
		end
		else
		begin
			if (REG_RD_I)
				REG_RDATA_O <= rdata_d;
			COMPENSATION_RANGE_D3_O <= RANGE_DISABLED;
			COMP_ACTIVE_O           <= {range_q[1] != RANGE_DISABLED,
			                            range_q[0] != RANGE_DISABLED};
			SYSTEM_SHUTDOWN_N_O     <= ~|over_w;
			CRIT_SUMMARY_O          <= |stat_w;
		end
	end

	assign COMPENSATION_RANGE_D1_O = range_q[0];
	assign COMPENSATION_RANGE_D2_O = range_q[1];
	assign GAIN_DETECT_ENABLE_O    = auto_q;
	assign SERIES_RES_CORRECT_O    = rec_q;
	assign CRIT_STATUS_O           = stat_w;
	assign CRIT_LINKED_O           = link_w;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_gain_ro_d1 : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(REG_WR_I && gain_hit_w[0] && sel_w[0] && !gdis_w[0] && !DET_VALID_I)
		|=> ($stable(range_q[0]) && $stable(auto_q[0])))
		else $error("diode-1 gain written while read-only");
	chk_gain_ro_d2 : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(REG_WR_I && gain_hit_w[1] && sel_w[1] && !gdis_w[1] && !DET_VALID_I)
		|=> ($stable(range_q[1]) && $stable(auto_q[1])))
		else $error("diode-2 gain written while read-only");
	chk_gain_write : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(REG_WR_I && gain_hit_w[0] && !gain_ro_w[0] && !gdis_w[0])
		|=> (range_q[0] == $past(REG_WDATA_I[2:0]) && auto_q[0] == $past(REG_WDATA_I[GAIN_AUTO_BIT])))
		else $error("writable gain register not updated");
	chk_gain_hwdis : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		gdis_w[1] |=> (!auto_q[1] && range_q[1] == RANGE_DISABLED))
		else $error("hardware disable not applied");
	chk_det_update : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(auto_q[0] && DET_VALID_I && !gdis_w[0] && !(REG_WR_I && gain_hit_w[0] && !gain_ro_w[0]))
		|=> range_q[0] == $past(DET_RANGE_D1_I))
		else $error("detected range not loaded");
	chk_rec_pin : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		sel_w[0] |=> rec_q[0] == $past(shdn_rec_w))
		else $error("correction bit not following select pin");
	chk_rec_lock : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(SW_LOCK_I && !init_q[2] && sel_w == 2'h0) |=> $stable(rec_q))
		else $error("locked correction register changed");
	chk_shutdown : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(|over_w) |=> !SYSTEM_SHUTDOWN_N_O)
		else $error("shutdown not asserted");
	chk_summary : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(stat_w == '0) |=> !CRIT_SUMMARY_O)
		else $error("summary stuck after status cleared");
	chk_strap_load : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(init_q[2] && !rec_wr_w && sel_w == 2'h0) |=> rec_q[1:0] == $past(strap_q))
		else $error("correction strap not loaded");
	chk_summary_set : assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(|stat_w) |=> CRIT_SUMMARY_O)
		else $error("summary not set");
endmodule : diode_cfg_bank

/* rtl/diode_cfg_pkg.sv */
// Purpose: constants shared by the diode configuration bank
// Assumes: byte-wide register port, 20 MHz system clock
// Notes:   offsets are byte addresses on the register port
package diode_cfg_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_GAIN_D1  = 8'h14;
	localparam logic [7:0] ADDR_GAIN_D2  = 8'h15;
	localparam logic [7:0] ADDR_REC      = 8'h17;
	localparam logic [7:0] ADDR_CRIT_D1  = 8'h19;
	localparam logic [7:0] ADDR_CRIT_D2  = 8'h1a;
	localparam logic [7:0] ADDR_CRIT_D3  = 8'h1b;
	localparam logic [7:0] ADDR_CRIT_INT = 8'h1d;
	// ----------------------------------------
	// field positions and codes
	// ----------------------------------------
	localparam int         GAIN_AUTO_BIT  = 4;
	localparam logic [2:0] RANGE_DISABLED = 3'h7;
	localparam int         NUM_CRIT       = 4;
	localparam int         SYNC_W         = 5;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic       GAIN_AUTO_RESET  = 1'h1;
	localparam logic [2:0] GAIN_RANGE_RESET = 3'h7;
	localparam logic       REC_D3_RESET     = 1'h1;
	localparam logic [7:0] CRIT_RESET       = 8'h64;
	localparam logic [7:0] READ_UNMAPPED    = 8'h00;

	// one-hot select of the critical limit addressed, zero if none
	function automatic logic [NUM_CRIT-1:0] crit_sel(input logic [7:0] addr);
		crit_sel = {addr == ADDR_CRIT_INT, addr == ADDR_CRIT_D3, addr == ADDR_CRIT_D2, addr == ADDR_CRIT_D1};
	endfunction : crit_sel
endpackage : diode_cfg_pkg

/* rtl/crit_if.sv */
// Purpose: bundle between the bank and one critical limit channel
// Assumes: all signals on the system clock
// Notes:   one instance per channel
`timescale 1ns/1ps
interface crit_if;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] temp;
	logic       clr;
	logic [7:0] limit;
	logic       linked;
	logic       over;
	logic       stat;
	modport chan (input wr, wdata, temp, clr, output limit, linked, over, stat);
	modport bank (output wr, wdata, temp, clr, input limit, linked, over, stat);
endinterface : crit_if

/* rtl/crit_chan.sv */
// Purpose: one write-once critical limit with link, compare and status
// Assumes: temperature is 8-bit two's complement on the system clock
// Notes:   the first write locks the limit and links the channel
`timescale 1ns/1ps
module crit_chan
	import diode_cfg_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// channel bundle
	crit_if.chan      bus
);
	logic [7:0] limit_q;
	logic       linked_q;
	logic       over_q;
	logic       stat_q;
	wire        take_w   = bus.wr && !linked_q;
	wire        over_d   = linked_q && ($signed(bus.temp) > $signed(limit_q));
	wire        stat_d   = over_q || (stat_q && !bus.clr);

	// ----------------------------------------
	// limit, lock/link, compare, status
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			limit_q  <= CRIT_RESET;
			linked_q <= 1'b0;
			over_q   <= 1'b0;
			stat_q   <= 1'b0;
		end
		else
		begin
			if (take_w)
				limit_q <= bus.wdata;
			if (bus.wr)
				linked_q <= 1'b1;
			over_q <= over_d;
			stat_q <= stat_d;
		end
	end

	assign bus.limit  = limit_q;
	assign bus.linked = linked_q;
	assign bus.over   = over_q;
	assign bus.stat   = stat_q;

	chk_crit_once : assert property (@(posedge clk_i) disable iff (!rstn_i)
		(linked_q && bus.wr) |=> ($stable(limit_q) && linked_q))
		else $error("locked critical limit changed");
	chk_crit_link : assert property (@(posedge clk_i) disable iff (!rstn_i)
		(bus.wr && !linked_q) |=> (linked_q && limit_q == $past(bus.wdata)))
		else $error("first limit write not taken or not linked");
	chk_crit_flag : assert property (@(posedge clk_i) disable iff (!rstn_i)
		(linked_q && ($signed(bus.temp) > $signed(limit_q))) |=> over_q ##1 stat_q)
		else $error("over limit not flagged");
endmodule : crit_chan

/* verif/reg_host.sv */
// Purpose: host model on the byte register port
// Assumes: requests launched 5 ns after the rising edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
module reg_host
(
	// clock
	input  wire logic       clk_i,
	// register port
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	initial
	begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		rd_o = 1'b0;
	end

	// one byte, strobe held across one taking edge
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#5;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_i);
		#5;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : write_byte

	// data registered on the taking edge, picked up just after it
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#5;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i);
		#5;
		d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
	endtask : read_byte
endmodule : reg_host

/* verif/test_diode_channel_config_and_crit_limits.sv */
// Purpose: self-checking bench for the diode configuration bank
// Assumes: 20 MHz clock, inputs moved 5 ns after the rising edge
// Notes:   strap value 2 at power-up, 1 at the mid-run reset
`timescale 1ns/1ps
module test_diode_channel_config_and_crit_limits
	import diode_cfg_pkg::*;
;
	logic       clk_sys = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr, wdata, rdata, rv;
	logic       wr, rd;
	logic       sel_d1 = 0, sel_d2 = 0, shdn_rec = 0, dis_d1 = 0, dis_d2 = 0, sw_lock = 0;
	logic       det_valid = 0, stat_clr = 0;
	logic [1:0] strap = 2'h2;
	logic [2:0] det_r1 = 3'h0, det_r2 = 3'h0, rng1, rng2, rng3, rec_out;
	logic [7:0] temp_d1 = 8'h00;
	logic [1:0] comp_act, auto_out;
	logic       shdn_n, summary;
	logic [3:0] status, linked;
	logic [7:0] crit_addr [4] = '{ADDR_CRIT_D1, ADDR_CRIT_D2, ADDR_CRIT_D3, ADDR_CRIT_INT};
	int         fail_count = 0;
	int         samples_checked = 0;

	always #25 clk_sys = ~clk_sys;

	reg_host host (.clk_i(clk_sys), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));

	diode_cfg_bank DUT (
		.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .SHUTDOWN_CHANNEL_SELECT_PIN_D1_I(sel_d1), .SHUTDOWN_CHANNEL_SELECT_PIN_D2_I(sel_d2),
		.SHDN_REC_I(shdn_rec), .GAIN_COMP_DIS_D1_I(dis_d1), .GAIN_COMP_DIS_D2_I(dis_d2),
		.REC_STRAP_I(strap), .SW_LOCK_I(sw_lock), .D3_EN_I(1'b1), .DET_VALID_I(det_valid),
		.DET_RANGE_D1_I(det_r1), .DET_RANGE_D2_I(det_r2), .TEMP_D1_I(temp_d1), .TEMP_D2_I(8'h00),
		.TEMP_D3_I(8'h00), .TEMP_INT_I(8'h00), .CRIT_STAT_CLR_I(stat_clr),
		.COMPENSATION_RANGE_D1_O(rng1), .COMPENSATION_RANGE_D2_O(rng2), .COMPENSATION_RANGE_D3_O(rng3),
		.COMP_ACTIVE_O(comp_act), .GAIN_DETECT_ENABLE_O(auto_out), .SERIES_RES_CORRECT_O(rec_out),
		.SYSTEM_SHUTDOWN_N_O(shdn_n), .CRIT_STATUS_O(status), .CRIT_LINKED_O(linked),
		.CRIT_SUMMARY_O(summary));

	// ----------------------------------------
	// compare, wait and verdict
	// ----------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask : cycles

	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		host.read_byte(ADDR_GAIN_D1, rv); chk("gain1", 8'h17, rv);
		host.read_byte(ADDR_REC, rv); chk("rec", 8'h06, rv);
		for (int i = 0; i < 4; i++)
		begin
			host.read_byte(crit_addr[i], rv); chk("crit", 8'h64, rv);
		end
		temp_d1 = 8'h7f;
		cycles(4);
		chk("unlinked", 8'h10, {3'h0, shdn_n, linked});
		chk("range3", 8'h07, rng3);
	endtask : t_reset

	task automatic t_gain_sel();
		host.write_byte(ADDR_GAIN_D1, 8'h03);
		host.read_byte(ADDR_GAIN_D1, rv); chk("gain1", 8'h03, rv);
		chk("rng1", 8'h0b, {4'h0, comp_act[0], rng1});
		sel_d1 = 1'b1;
		sel_d2 = 1'b1;
		cycles(3);
		host.write_byte(ADDR_GAIN_D1, 8'h05);
		host.write_byte(ADDR_GAIN_D2, 8'h05);
		host.read_byte(ADDR_GAIN_D1, rv); chk("gain1", 8'h03, rv);
		host.read_byte(ADDR_GAIN_D2, rv); chk("gain2", 8'h17, rv);
		shdn_rec = 1'b1;
		host.write_byte(ADDR_REC, 8'h00);
		host.read_byte(ADDR_REC, rv); chk("rec", 8'h03, rv);
		chk("rec_out", 8'h03, rec_out);
		sel_d1 = 1'b0;
		sel_d2 = 1'b0;
		cycles(3);
	endtask : t_gain_sel

	task automatic t_detect();
		host.write_byte(ADDR_GAIN_D2, 8'h10);
		det_r2 = 3'h2;
		det_valid = 1'b1;
		cycles(1);
		det_valid = 1'b0;
		host.read_byte(ADDR_GAIN_D2, rv); chk("gain2", 8'h12, rv);
		dis_d2 = 1'b1;
		cycles(4);
		host.read_byte(ADDR_GAIN_D2, rv); chk("gain2", 8'h07, rv);
		chk("active", 8'h00, {6'h0, comp_act[1], auto_out[1]});
		dis_d2 = 1'b0;
	endtask : t_detect

	task automatic t_lock();
		sw_lock = 1'b1;
		host.write_byte(ADDR_GAIN_D1, 8'h06);
		host.write_byte(ADDR_REC, 8'h04);
		host.read_byte(ADDR_GAIN_D1, rv); chk("gain1", 8'h03, rv);
		host.read_byte(ADDR_REC, rv); chk("rec", 8'h03, rv);
		sw_lock = 1'b0;
		host.write_byte(ADDR_GAIN_D1, 8'h06);
		host.read_byte(ADDR_GAIN_D1, rv); chk("gain1", 8'h06, rv);
		chk("active6", 8'h01, {7'h0, comp_act[0]});
	endtask : t_lock

	task automatic t_crit();
		temp_d1 = 8'h40;
		for (int i = 0; i < 4; i++)
		begin
			host.write_byte(crit_addr[i], 8'h50 + i[7:0]);
			chk("linked", 8'h01 << i, {4'h0, linked} & (8'h01 << i));
		end
		host.write_byte(ADDR_CRIT_D1, 8'h20);
		host.read_byte(ADDR_CRIT_D1, rv); chk("crit1", 8'h50, rv);
		chk("linked", 8'h0f, {4'h0, linked});
		temp_d1 = 8'h51;
		cycles(4);
		chk("trip", 8'h11, {2'h0, shdn_n, summary, status});
		temp_d1 = 8'h50;
		cycles(3);
		stat_clr = 1'b1;
		cycles(1);
		stat_clr = 1'b0;
		cycles(3);
		chk("clear", 8'h20, {2'h0, shdn_n, summary, status});
	endtask : t_crit

	task automatic t_strap();
		strap = 2'h1;
		rstn = 1'b0;
		cycles(3);
		rstn = 1'b1;
		cycles(3);
		host.read_byte(ADDR_REC, rv);
		chk("strap", 8'h05, rv);
		chk("relink", 8'h10, {3'h0, shdn_n, linked});
		host.write_byte(ADDR_CRIT_D1, 8'h30);
		host.read_byte(ADDR_CRIT_D1, rv);
		chk("crit1", 8'h30, rv);
	endtask : t_strap

	initial
	begin
		#200000;
		fail_count++;
		final_report();
	end

	initial
	begin
		cycles(3);
		rstn = 1'b1;
		cycles(3);
		t_reset();
		t_gain_sel();
		t_detect();
		t_lock();
		t_crit();
		t_strap();
		final_report();
	end
endmodule : test_diode_channel_config_and_crit_limits
